// [design/fprc_cfg.svh]
// Timing and field constants for the fuse PROM host controller
`ifndef FPRC_CFG_SVH
`define FPRC_CFG_SVH
`define FPRC_CLK_NS 40
`define FPRC_WORDS 1024
`define FPRC_ADDR_W 10
`define FPRC_DATA_W 8
`define FPRC_ERASED_WORD 8'hFF
// Pulse width in microseconds: least, recommended, most
`define FPRC_PW_MIN_US 50
`define FPRC_PW_REC_US 180
`define FPRC_PW_MAX_US 50000
`define FPRC_PW_CYC ((`FPRC_PW_REC_US * 1000) / `FPRC_CLK_NS)
// Duty cycle in percent
`define FPRC_DUTY_PCT 20
`define FPRC_GAP_CYC ((`FPRC_PW_CYC * (100 - `FPRC_DUTY_PCT)) / `FPRC_DUTY_PCT)
`define FPRC_MAX_PULSES 8
// Address access delay in ns, rounded up to cycles
`define FPRC_TAA_NS 70
`define FPRC_TAA_CYC ((`FPRC_TAA_NS + `FPRC_CLK_NS - 1) / `FPRC_CLK_NS)
// Settle time after a supply change before the verify sample
`define FPRC_SETTLE_CYC 16
`endif

// [design/fprc_pkg.sv]
// Types for the fuse PROM host controller
package fprc_pkg;
    typedef enum logic [1:0] {FPRC_OK, FPRC_FAIL} fprc_result_t;
    typedef enum {
        FPRC_IDLE, FPRC_RD_WAIT, FPRC_PICK, FPRC_SETUP, FPRC_PULSE,
        FPRC_COOL, FPRC_VERIFY, FPRC_DONE
    } fprc_state_t;
endpackage

// [design/fprc_sync_if.sv]
// Group of synchronised pins handed from the input stage to the controller
`timescale 1ns/1ps
interface fprc_sync_if #(parameter int DW = 8);
    logic [DW-1:0] data;
    modport src (output data);
    modport dst (input data);
endinterface

// [design/fprc_sync3.sv]
// Three-stage synchroniser with agreement filter for the PROM data pins
`timescale 1ns/1ps
`include "fprc_cfg.svh"
module fprc_sync3 import fprc_pkg::*; #(
    parameter int DW = 8
) (
    input wire logic clk_i, // System clock
    input wire logic resetn_i, // Synchronous reset, active low
    input wire logic [DW-1:0] pin_i, // Raw pins
    fprc_sync_if.src sync_o // Filtered value
);
    typedef struct packed {
        logic [DW-1:0] s1;
        logic [DW-1:0] s2;
        logic [DW-1:0] s3;
        logic [DW-1:0] val;
    } fprc_sync_t;
    fprc_sync_t st_reg, st_next;
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin_i;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // A change counts only once stages two and three agree
        for (int i = 0; i < DW; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.val[i] = st_reg.s3[i];
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_reg <= '1;
        end else begin
            st_reg <= st_next;
        end
    end
    assign sync_o.data = st_reg.val;
endmodule // fprc_sync3

// [design/fprc_host.sv]
// Host controller that reads and field-programs a 1024x8 fuse PROM
// Notes on behaviour
// RQ1 - The PROM holds 1024 eight-bit words on a ten-bit word address.
// RQ2 - The PROM drives its outputs only while all four selects are asserted.
// RQ3 - Any other select pattern leaves all eight PROM outputs off.
// RQ4 - Open-collector and tri-state builds differ only in their output stage.
// RQ5 - A read selects the address and samples after the access delay.
// RQ6 - A blank PROM reads one in every bit.
// RQ7 - Programming only turns a one into a zero, and never back.
// RQ8 - The address comes first, then the chip is deselected before any pulse.
// RQ9 - Only the output of the bit to be cleared receives a pulse.
// RQ10 - Pulses last 0.05 to 50 ms, 0.18 ms by default, one to eight per bit.
// RQ11 - Pulses run at about 20 percent duty cycle.
// RQ12 - Other outputs stay open or high while one is pulsed.
// RQ13 - Verify ends the pulse, lowers supply, selects fully and expects zero.
// RQ14 - Select, pulse and verify repeat per bit, one bit per pass.
// RQ15 - Address pins are driven to defined levels throughout programming.
// RQ16 - Bits wanted as one are skipped; pulsing stops once verify reads zero.
`timescale 1ns/1ps
`include "fprc_cfg.svh"
module fprc_host import fprc_pkg::*; #(
    parameter int AW = `FPRC_ADDR_W,
    parameter int DW = `FPRC_DATA_W,
    parameter int PW_CYC = `FPRC_PW_CYC,
    parameter int GAP_CYC = `FPRC_GAP_CYC,
    parameter int MAX_PULSES = `FPRC_MAX_PULSES
) (
    input wire logic clk_i, // 25 MHz clock
    input wire logic resetn_i, // Synchronous reset, active low
    input wire logic rd_req_i, // Start a read, pulse
    input wire logic pg_req_i, // Start programming a word, pulse
    input wire logic [AW-1:0] addr_i, // Word address
    input wire logic [DW-1:0] wdata_i, // Wanted word
    output logic busy_o, // Operation in progress
    output logic done_o, // Operation finished, pulse
    output logic fail_o, // Bit would not clear, with done
    output logic [DW-1:0] rdata_o, // Read or verify data
    output logic [AW-1:0] word_address_o, // PROM address pins
    output logic select_low_a_o, // Low-active select
    output logic select_low_b_o, // Low-active select
    output logic select_high_a_o, // High-active select
    output logic select_high_b_o, // High-active select
    input wire logic [DW-1:0] data_out_i, // PROM data pins
    output logic [DW-1:0] pulse_o, // Programming pulse, one-hot
    output logic low_vcc_o // Request verify supply
);
    localparam int CW = $clog2(PW_CYC + GAP_CYC + `FPRC_SETTLE_CYC + 2);
    // Refuse sizes the fixed one-hot and bit index logic cannot serve
    if (AW != `FPRC_ADDR_W || DW != `FPRC_DATA_W) begin : g_bad_size
        $error("fprc_host: PROM is 1024 words of 8 bits");
    end
    if (PW_CYC < 1 || GAP_CYC < 1 || MAX_PULSES < 1 || MAX_PULSES > 8)
    begin : g_bad_pulse
        $error("fprc_host: pulse figures out of range");
    end
    // ==========================================================
    // State
    typedef struct packed {
        fprc_state_t st;
        logic [AW-1:0] addr;
        logic [DW-1:0] want;
        logic [DW-1:0] rdata;
        logic [2:0] bit_ix;
        logic [3:0] pulses;
        logic [CW-1:0] cnt;
        logic [CW-1:0] pw_len;
        logic sel;
        logic done;
        logic fail;
        logic pgm;
    } fprc_host_t;
    fprc_host_t q_reg, q_next;
    fprc_sync_if #(.DW(DW)) din ();
    fprc_sync3 #(.DW(DW)) u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(data_out_i),
        .sync_o(din)
    );
    // Wait covers access delay plus the three-stage input filter
    localparam int RD_CYC = `FPRC_TAA_CYC + 4;
    function automatic logic [DW-1:0] onehot(input logic [2:0] ix);
        onehot = '0;
        onehot[ix] = 1'b1;
    endfunction
    // ==========================================================
    // Sequencer
    always_comb begin
        q_next = q_reg;
        q_next.done = 1'b0;
        // Length of the pulse seen on the pins, for the width check
        q_next.pw_len = (pulse_o != '0) ? CW'(q_reg.pw_len + 1'b1) : '0;
        case (q_reg.st)
            FPRC_IDLE: begin
                if (rd_req_i || pg_req_i) begin
                    q_next.addr = addr_i; // [RQ15] [RQ1]
                    q_next.want = wdata_i;
                    q_next.pgm = pg_req_i && !rd_req_i;
                    q_next.fail = 1'b0;
                    q_next.bit_ix = '0;
                    q_next.sel = 1'b1; // [RQ5]
                    q_next.cnt = CW'(RD_CYC);
                    q_next.st = FPRC_RD_WAIT;
                end
            end
            FPRC_RD_WAIT: begin
                if (q_reg.cnt != '0) begin
                    q_next.cnt = q_reg.cnt - 1'b1;
                end else begin
                    q_next.rdata = din.data; // [RQ5]
                    q_next.st = q_reg.pgm ? FPRC_PICK : FPRC_DONE;
                end
            end
            FPRC_PICK: begin
                // Skip bits wanted high or already cleared [RQ16] [RQ7]
                if (q_reg.want[q_reg.bit_ix] || !q_reg.rdata[q_reg.bit_ix]) begin
                    if (q_reg.bit_ix == 3'h7) begin
                        q_next.st = FPRC_DONE;
                    end else begin
                        q_next.bit_ix = q_reg.bit_ix + 1'b1; // [RQ14]
                    end
                end else begin
                    q_next.pulses = '0;
                    q_next.sel = 1'b0; // [RQ8]
                    q_next.cnt = CW'(GAP_CYC);
                    q_next.st = FPRC_SETUP;
                end
            end
            FPRC_SETUP: begin
                if (q_reg.cnt != '0) begin
                    q_next.cnt = q_reg.cnt - 1'b1;
                end else begin
                    q_next.cnt = CW'(PW_CYC - 1);
                    q_next.pulses = q_reg.pulses + 1'b1;
                    q_next.st = FPRC_PULSE;
                end
            end
            FPRC_PULSE: begin
                if (q_reg.cnt != '0) begin
                    q_next.cnt = q_reg.cnt - 1'b1; // [RQ10]
                end else begin
                    q_next.cnt = CW'(`FPRC_SETTLE_CYC);
                    q_next.st = FPRC_COOL;
                end
            end
            FPRC_COOL: begin
                // Supply lowered, then selects fully asserted [RQ13]
                if (q_reg.cnt != '0) begin
                    q_next.cnt = q_reg.cnt - 1'b1;
                end else begin
                    q_next.sel = 1'b1;
                    q_next.cnt = CW'(RD_CYC);
                    q_next.st = FPRC_VERIFY;
                end
            end
            FPRC_VERIFY: begin
                if (q_reg.cnt != '0) begin
                    q_next.cnt = q_reg.cnt - 1'b1;
                end else begin
                    q_next.rdata = din.data;
                    q_next.sel = 1'b0;
                    if (!din.data[q_reg.bit_ix]) begin
                        q_next.rdata[q_reg.bit_ix] = 1'b1;
                        q_next.want[q_reg.bit_ix] = 1'b1; // [RQ16]
                        q_next.sel = 1'b1;
                        q_next.st = FPRC_PICK;
                    end else if (q_reg.pulses == 4'(MAX_PULSES)) begin
                        q_next.fail = 1'b1; // [RQ10]
                        q_next.st = FPRC_DONE;
                    end else begin
                        // Off-time keeps duty near target [RQ11]
                        q_next.cnt = CW'(GAP_CYC);
                        q_next.st = FPRC_SETUP;
                    end
                end
            end
            FPRC_DONE: begin
                q_next.done = 1'b1;
                q_next.sel = 1'b0;
                q_next.st = FPRC_IDLE;
            end
            default: q_next.st = FPRC_IDLE;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q_reg <= '{st: FPRC_IDLE, rdata: `FPRC_ERASED_WORD, default: '0};
        end else begin
            q_reg <= q_next;
        end
    end
    // ==========================================================
    // Pins
    assign busy_o = (q_reg.st != FPRC_IDLE);
    assign done_o = q_reg.done;
    assign fail_o = q_reg.fail;
    assign rdata_o = q_reg.rdata;
    assign word_address_o = q_reg.addr; // [RQ15]
    // Deselect drives only select_low_a_o high; select_low_b_o stays low [RQ2] [RQ3] [RQ8]
    assign select_low_a_o = !q_reg.sel;
    assign select_low_b_o = 1'b0;
    assign select_high_a_o = 1'b1;
    assign select_high_b_o = 1'b1;
    // One bit pulsed, others left open [RQ9] [RQ12] [RQ4]
    assign pulse_o = (q_reg.st == FPRC_PULSE) ? onehot(q_reg.bit_ix) : '0;
    assign low_vcc_o = (q_reg.st == FPRC_COOL) || (q_reg.st == FPRC_VERIFY);
    // ==========================================================
    // Checks
    sequence pulse_seq;
        pulse_o != '0 ##1 pulse_o == '0;
    endsequence
    pulse_desel_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pulse_o != '0 |-> select_low_a_o) // [RQ8]
        else $error("pulse while selected");
    pulse_onehot_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $onehot0(pulse_o)) // [RQ9]
        else $error("more than one output pulsed");
    pulse_width_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pulse_seq |-> q_reg.pw_len == CW'(PW_CYC)) // [RQ10]
        else $error("pulse width wrong");
    verify_low_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pulse_seq |-> low_vcc_o) // [RQ13]
        else $error("no low supply after pulse");
    verify_sel_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (q_reg.st == FPRC_VERIFY) |-> !select_low_a_o && low_vcc_o) // [RQ13]
        else $error("verify without full select");
    pulse_count_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        q_reg.pulses <= 4'(MAX_PULSES)) // [RQ10]
        else $error("too many pulses");
    skip_one_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pulse_o != '0 |-> (pulse_o & q_reg.want) == '0) // [RQ16]
        else $error("pulsing a bit wanted high");
    addr_stable_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        busy_o && $past(busy_o) |-> $stable(word_address_o)) // [RQ15]
        else $error("address moved during operation");
endmodule // fprc_host

// [dv/fprc_prom_model.sv]
// Behavioural fuse PROM standing on the far side of the host controller
`timescale 1ns/1ps
module fprc_prom_model (
    input wire logic clk_i, // Sampling clock
    input wire logic [9:0] word_address_i, // Address pins
    input wire logic select_low_a_i, // Low-active select
    input wire logic select_low_b_i, // Low-active select
    input wire logic select_high_a_i, // High-active select
    input wire logic select_high_b_i, // High-active select
    input wire logic [7:0] pulse_i, // Programming pulses
    input wire logic low_vcc_i, // Verify supply applied
    input wire logic [3:0] need_i, // Pulses a fuse needs
    input wire logic [9:0] stuck_addr_i, // Word with a stubborn fuse
    input wire logic [7:0] stuck_mask_i, // Fuses that never open
    output logic [7:0] data_out_o, // Data pins, pulled up when off
    output int viol_o // Misuse seen
);
    logic [7:0] fuse_mem [0:1023];
    logic [7:0] prev_pulse = 8'h00;
    logic [7:0] cur_bit = 8'h00;
    logic [9:0] cur_addr = 10'h000;
    logic sel;
    int cnt = 0;
    int viol = 0;
    assign viol_o = viol;
    assign sel = !select_low_a_i && !select_low_b_i && select_high_a_i
                 && select_high_b_i;
    // Off pins show the pull-up, never the last driven word
    assign data_out_o = sel ? fuse_mem[word_address_i] : 8'hFF;
    initial begin
        for (int i = 0; i < 1024; i++) begin
            fuse_mem[i] = 8'hFF;
        end
    end
    always @(posedge clk_i) begin
        prev_pulse <= pulse_i;
        if (pulse_i != 8'h00 && (sel || low_vcc_i
            || $countones(pulse_i) != 1)) begin
            viol <= viol + 1;
        end
        if (prev_pulse != 8'h00 && pulse_i == 8'h00) begin
            cnt = (prev_pulse == cur_bit && word_address_i == cur_addr)
                  ? cnt + 1 : 1;
            cur_bit <= prev_pulse;
            cur_addr <= word_address_i;
            if (cnt > 8) begin
                viol <= viol + 1;
            end
            // A fuse only ever opens, so a bit can only fall to zero
            if (cnt >= need_i && !(word_address_i == stuck_addr_i
                && (prev_pulse & stuck_mask_i) != 8'h00)) begin
                fuse_mem[word_address_i] <=
                    fuse_mem[word_address_i] & ~prev_pulse;
            end
        end
    end
endmodule // fprc_prom_model

// [dv/fuse_prom_read_and_program_tb_top.sv]
// Self-checking bench for the fuse PROM host controller
`timescale 1ns/1ps
module fuse_prom_read_and_program_tb_top;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic rd_req_i = 1'b0;
    logic pg_req_i = 1'b0;
    logic [9:0] addr_i = 10'h000;
    logic [7:0] wdata_i = 8'h00;
    logic [3:0] need = 4'h1;
    logic [9:0] stuck_addr = 10'h006;
    logic [7:0] stuck_mask = 8'h00;
    logic busy_o, done_o, fail_o, low_vcc_o;
    logic sel_la, sel_lb, sel_ha, sel_hb;
    logic [7:0] rdata_o, pulse_o, data_out_i;
    logic [9:0] word_address_o;
    int viol;
    int num_errors = 0;
    int checks = 0;
    int cyc;
    fprc_host #(.PW_CYC(4), .GAP_CYC(16)) u_dut (.clk_i(clk_i),
        .resetn_i(resetn_i), .rd_req_i(rd_req_i), .pg_req_i(pg_req_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy_o),
        .done_o(done_o), .fail_o(fail_o), .rdata_o(rdata_o),
        .word_address_o(word_address_o), .select_low_a_o(sel_la),
        .select_low_b_o(sel_lb), .select_high_a_o(sel_ha),
        .select_high_b_o(sel_hb), .data_out_i(data_out_i),
        .pulse_o(pulse_o), .low_vcc_o(low_vcc_o));
    fprc_prom_model u_prom (.clk_i(clk_i), .word_address_i(word_address_o),
        .select_low_a_i(sel_la), .select_low_b_i(sel_lb),
        .select_high_a_i(sel_ha), .select_high_b_i(sel_hb),
        .pulse_i(pulse_o), .low_vcc_i(low_vcc_o), .need_i(need),
        .stuck_addr_i(stuck_addr), .stuck_mask_i(stuck_mask),
        .data_out_o(data_out_i), .viol_o(viol));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // ==========================================
    // Shared tasks
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic run_op(input logic rd, input logic [9:0] a,
                          input logic [7:0] w);
        @(posedge clk_i);
        #1;
        rd_req_i = rd;
        pg_req_i = !rd;
        addr_i = a;
        wdata_i = w;
        @(posedge clk_i);
        #1;
        rd_req_i = 1'b0;
        pg_req_i = 1'b0;
        cyc = 1;
        // A hung operation must still reach the verdict
        while (done_o !== 1'b1 && cyc < 5000) begin
            @(posedge clk_i);
            #1;
            cyc++;
        end
        if (cyc >= 5000) begin
            num_errors++;
            wrap_up();
        end
        check("address pins", a, word_address_o);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_blank_read();
        logic [9:0] addrs [3] = '{10'h000, 10'h3FF, 10'h155};
        foreach (addrs[i]) begin
            run_op(1'b1, addrs[i], 8'h00);
            check("read latency", 16'd9, cyc);
            check("blank word", 16'h00FF, rdata_o);
            @(posedge clk_i);
            #1;
            check("idle pins", 16'h0001, {busy_o, sel_la});
        end
    endtask
    task automatic t_program();
        run_op(1'b0, 10'h3FF, 8'hA5);
        check("program fail", 16'h0000, fail_o);
        run_op(1'b1, 10'h3FF, 8'h00);
        check("programmed word", 16'h00A5, rdata_o);
        run_op(1'b0, 10'h3FF, 8'hFF);
        run_op(1'b1, 10'h3FF, 8'h00);
        check("no return to one", 16'h00A5, rdata_o);
        need = 4'h3;
        run_op(1'b0, 10'h005, 8'h00);
        check("multi pulse fail", 16'h0000, fail_o);
        run_op(1'b1, 10'h005, 8'h00);
        check("all cleared", 16'h0000, rdata_o);
        check("pin misuse", 16'd0, viol);
    endtask
    task automatic t_stuck();
        need = 4'h1;
        // Bit 0 clears first; bit 1 never opens, which ends the word
        stuck_mask = 8'h02;
        run_op(1'b0, 10'h006, 8'hFC);
        check("stuck fail", 16'h0001, fail_o);
        run_op(1'b1, 10'h006, 8'h00);
        check("stuck word", 16'h00FE, rdata_o);
        check("pulse limit", 16'd0, viol);
    endtask
    task automatic t_refuse();
        @(posedge clk_i);
        #1;
        rd_req_i = 1'b1;
        addr_i = 10'h3FF;
        repeat (3) @(posedge clk_i);
        #1;
        rd_req_i = 1'b0;
        pg_req_i = 1'b1;
        addr_i = 10'h010;
        @(posedge clk_i);
        #1;
        pg_req_i = 1'b0;
        repeat (40) begin
            @(posedge clk_i);
            #1;
        end
        check("refused busy", 16'h0000, {busy_o, done_o});
        check("first read kept", 16'h00A5, rdata_o);
        run_op(1'b1, 10'h010, 8'h00);
        check("refused program", 16'h00FF, rdata_o);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        #1;
        check("reset pins", 16'h1000, {busy_o, done_o, fail_o, sel_la,
              low_vcc_o, pulse_o, word_address_o[2:0]});
        check("reset data", 16'h00FF, rdata_o);
        resetn_i = 1'b1;
        t_blank_read();
        t_program();
        t_stuck();
        t_refuse();
        check("tied selects", 16'h0003, {sel_lb, sel_ha, sel_hb});
        wrap_up();
    end
endmodule // fuse_prom_read_and_program_tb_top
